/* hdl/vstage_pkg.sv */
// constants shared by the sequence-voltage stage timer
package vstage_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int TICK_MS = 5;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int OP_W = 19;
   localparam int REL_W = 15;
   localparam int RATIO_W = 16;
   localparam int DIAL_W = 13;
   localparam int EXP_W = 12;
   localparam int RATIO_FRAC = 12;
   localparam logic [15:0] RATIO_ONE = 16'h1000;
   localparam logic [15:0] RATIO_OVER_REL = 16'h0f85;
   localparam logic [15:0] RATIO_UNDER_REL = 16'h107b;
   localparam logic [1:0] SEL_FIXED = 2'h1;
   localparam logic [1:0] SEL_INVERSE = 2'h2;
   localparam logic [1:0] SEL_NO = 2'h1;
   localparam logic [1:0] SEL_YES = 2'h2;
   localparam logic [18:0] MAX_DELAY_TICKS = 19'h57e40;
   localparam logic [18:0] FIXED_DELAY_DEF = 19'h00008;
   localparam int RELEASE_DELAY_DEF_MS = 60;
   localparam logic [14:0] RELEASE_DELAY_DEF = 15'(RELEASE_DELAY_DEF_MS / TICK_MS);
   localparam logic [12:0] DIAL_K_DEF = 13'h0005;
   localparam logic [11:0] EXP_A_DEF = 12'h064;
   localparam logic [1:0] DELAY_TYPE_DEF = 2'h1;
   localparam logic [1:0] DELAYED_RELEASE_DEF = 2'h2;
   localparam logic [1:0] RESET_AFTER_DEF = 2'h2;
   localparam logic [1:0] CONTINUE_DEF = 2'h1;
   localparam logic [15:0] HUNDREDTH_MUL = 16'h028f;
   localparam logic [5:0] DIV_STEPS = 6'h20;
endpackage

/* hdl/inverse_time_calc.sv */
// inverse-time operating delay in ticks from ratio, dial and exponent
`timescale 1ns/1ps
`default_nettype none
module inverse_time_calc
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_under,
   input wire logic [15:0] i_ratio,
   input wire logic [12:0] i_dial_k,
   input wire logic [11:0] i_inverse_time_mode_exp,
   output logic [18:0] o_ticks
);
   typedef enum logic {LOAD, DIVIDE} calc_state_t;
   typedef struct packed {
      calc_state_t st;
      logic [5:0] step;
      logic [32:0] rem;
      logic [31:0] quo;
      logic [31:0] dvs;
      logic [18:0] ticks;
   } calc_t;
   calc_t q, d;

   logic [4:0] lead;
   logic [15:0] mant;
   logic signed [17:0] log2r;
   logic signed [30:0] prod;
   logic signed [47:0] scaled;
   logic signed [23:0] y;
   logic signed [11:0] n;
   logic [31:0] pow;
   logic [31:0] dvs_new;
   logic [32:0] trial;

   // log2 and exp2 use the straight-line mantissa approximation: cheap, within about 6 %
   always_comb
   begin
      lead = 5'h00;
      for (int i = 0; i < 16; i++)
      begin
         if (i_ratio[i])
         begin
            lead = 5'(i);
         end
      end
      mant = i_ratio << (5'h0f - lead);
      log2r = $signed({1'b0, lead, 12'h000}) - $signed(18'h0c000) + $signed({6'h00, mant[14:3]});
      prod = 31'(log2r * $signed({1'b0, i_inverse_time_mode_exp}));
      scaled = 48'(prod * $signed({1'b0, vstage_pkg::HUNDREDTH_MUL}));
      y = 24'(scaled >>> 16);
      n = 12'(y >>> vstage_pkg::RATIO_FRAC);
      if (i_ratio == 16'h0000)
      begin
         pow = 32'h00000000;
      end
      else if (n > 12'sh013)
      begin
         pow = 32'hffffffff;
      end
      else if (n >= 12'sh000)
      begin
         pow = {19'h00000, 1'b1, y[11:0]} << n[4:0];
      end
      else if (n < -12'sh00d)
      begin
         pow = 32'h00000000;
      end
      else
      begin
         pow = {19'h00000, 1'b1, y[11:0]} >> 5'(-n);
      end
      dvs_new = i_under ? (32'h00001000 - pow) : (pow - 32'h00001000);
      if (i_under ? (pow >= 32'h00001000) : (pow <= 32'h00001000))
      begin
         dvs_new = 32'h00000000;
      end
   end

   always_comb
   begin
      d = q;
      trial = {q.rem[31:0], q.quo[31]};
      case (q.st)
         LOAD:
         begin
            d.rem = 33'h000000000;
            // k in hundredths, tick 5 ms: ticks = 2k / |r^a - 1|
            d.quo = {6'h00, i_dial_k, 13'h0000};
            d.dvs = dvs_new;
            d.step = 6'h00;
            d.st = DIVIDE;
         end
         DIVIDE:
         begin
            if (trial >= {1'b0, q.dvs})
            begin
               d.rem = trial - {1'b0, q.dvs};
               d.quo = {q.quo[30:0], 1'b1};
            end
            else
            begin
               d.rem = trial;
               d.quo = {q.quo[30:0], 1'b0};
            end
            d.step = q.step + 6'h01;
            if (q.step == vstage_pkg::DIV_STEPS - 6'h01)
            begin
               d.st = LOAD;
               if (q.dvs == 32'h00000000 || d.quo > {13'h0000, vstage_pkg::MAX_DELAY_TICKS})
               begin
                  d.ticks = vstage_pkg::MAX_DELAY_TICKS;
               end
               else
               begin
                  d.ticks = d.quo[18:0];
               end
            end
         end
         default:
         begin
            d.st = LOAD;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         q <= '{st: LOAD, step: 6'h00, rem: 33'h000000000, quo: 32'h00000000,
                dvs: 32'h00000000, ticks: vstage_pkg::MAX_DELAY_TICKS};
      end
      else
      begin
         q <= d;
      end
   end

   assign o_ticks = q.ticks;
endmodule
`default_nettype wire

/* hdl/voltage_stage_trip_release_timer.sv */
// operating and release timing of one sequence-voltage protection stage
// What this block does
// - instant: trip together with start
// - fixed mode: trip after set delay
// - inverse: k over ratio power difference
// - type code 1 fixed, 2 inverse
// - fixed delay 5 ms steps, zero instant
// - dial k in 0.01 s steps
// - exponent a in 0.01 steps
// - settings act only in their mode
// - release delay holds start after drop
// - delayed release code 1 off, 2 on
// - counter clears after full release delay
// - optionally keep counting during release
// - default 60 ms release, time held
// - no trip during release interval
// - blocked at pick-up: blocked, no timer
// - later block drops start at once, timers release like pick-up drop
// - release hysteresis 97 / 103 percent
`timescale 1ns/1ps
`default_nettype none
module voltage_stage_trip_release_timer
#(
   parameter int TICK_CYCLES = vstage_pkg::TICK_CYCLES
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_under,
   input wire logic [15:0] i_ratio,
   input wire logic i_block,
   input wire logic [1:0] i_delay_type,
   input wire logic [18:0] i_fixed_delay,
   input wire logic [12:0] i_dial_k,
   input wire logic [11:0] i_inverse_time_mode_exp,
   input wire logic [14:0] i_release_delay,
   input wire logic [1:0] i_delayed_release,
   input wire logic [1:0] i_reset_after_release,
   input wire logic [1:0] i_continue_release,
   output logic o_start,
   output logic o_trip,
   output logic o_blocked,
   output logic o_releasing,
   output logic [18:0] o_op_ticks
);
   typedef struct packed {
      logic [16:0] div_cnt;
      logic pick;
      logic start;
      logic trip;
      logic blocked;
      logic rel_active;
      logic [14:0] rel_cnt;
      logic [18:0] op_cnt;
   } stage_t;
   stage_t q, d;

   localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

   logic [18:0] inv_ticks;
   logic [18:0] target;
   logic [18:0] op_inc;
   logic [14:0] rel_n;
   logic tick;
   logic pick_nx;
   logic run;

   inverse_time_calc calc
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_under(i_under),
      .i_ratio(i_ratio),
      .i_dial_k(i_dial_k),
      .i_inverse_time_mode_exp(i_inverse_time_mode_exp),
      .o_ticks(inv_ticks)
   );

   always_comb
   begin
      d = q;
      tick = (q.div_cnt == TICK_LAST);
      d.div_cnt = tick ? 17'h00000 : q.div_cnt + 17'h00001;
      // any code other than inverse runs the fixed delay, so a bad code fails safe
      target = (i_delay_type == vstage_pkg::SEL_INVERSE) ? inv_ticks : i_fixed_delay;
      op_inc = (q.op_cnt == vstage_pkg::MAX_DELAY_TICKS) ? q.op_cnt : q.op_cnt + 19'h00001;
      rel_n = q.rel_active ? q.rel_cnt + 15'h0001 : 15'h0001;
      if (i_under)
      begin
         pick_nx = q.pick ? (i_ratio <= vstage_pkg::RATIO_UNDER_REL) : (i_ratio < vstage_pkg::RATIO_ONE);
      end
      else
      begin
         pick_nx = q.pick ? (i_ratio >= vstage_pkg::RATIO_OVER_REL) : (i_ratio > vstage_pkg::RATIO_ONE);
      end
      run = pick_nx & ~i_block;
      if (tick)
      begin
         d.pick = pick_nx;
         d.blocked = pick_nx & i_block;
         if (run)
         begin
            d.start = 1'b1;
            d.rel_active = 1'b0;
            d.rel_cnt = 15'h0000;
            d.op_cnt = op_inc;
            // zero delay meets the first count, so trip rises with start
            d.trip = (op_inc >= target);
         end
         else if (q.start | q.rel_active)
         begin
            d.trip = 1'b0;
            if (rel_n >= i_release_delay)
            begin
               d.start = 1'b0;
               d.rel_active = 1'b0;
               d.rel_cnt = 15'h0000;
               d.op_cnt = 19'h00000;
            end
            else
            begin
               d.rel_active = 1'b1;
               d.rel_cnt = rel_n;
               // a block drops start at once, only the timers see the release hold
               d.start = (i_delayed_release == vstage_pkg::SEL_YES) & ~(pick_nx & i_block);
               if (i_continue_release == vstage_pkg::SEL_YES)
               begin
                  d.op_cnt = op_inc;
               end
               else if (i_reset_after_release == vstage_pkg::SEL_YES)
               begin
                  d.op_cnt = q.op_cnt;
               end
               else
               begin
                  d.op_cnt = 19'h00000;
               end
            end
         end
         else
         begin
            d.start = 1'b0;
            d.trip = 1'b0;
            d.op_cnt = 19'h00000;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_start = q.start;
   assign o_trip = q.trip;
   assign o_blocked = q.blocked;
   assign o_releasing = q.rel_active;
   assign o_op_ticks = q.op_cnt;
endmodule
`default_nettype wire

/* sim/vstage_assertions.sv */
// port checks for the stage trip and release timer
`timescale 1ns/1ps
`default_nettype none
module vstage_assertions
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [1:0] i_delay_type,
   input wire logic [18:0] i_fixed_delay,
   input wire logic [14:0] i_release_delay,
   input wire logic [1:0] i_delayed_release,
   input wire logic o_start,
   input wire logic o_trip,
   input wire logic o_blocked,
   input wire logic o_releasing,
   input wire logic [18:0] o_op_ticks
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire fx = i_delay_type == vstage_pkg::SEL_FIXED;
   // a one-tick release may expire before the interval ever shows
   wire dly = i_delayed_release == vstage_pkg::SEL_YES && i_release_delay > 15'h0001;
   trip_in_run_a: assert property (o_trip |-> o_start && !o_releasing)
      else $error("trip outside run");
   blk_no_start_a: assert property (o_blocked |-> !o_start && !o_trip)
      else $error("start while blocked");
   instant_trip_a: assert property ($rose(o_start) && fx && i_fixed_delay == 19'h00000 |-> o_trip)
      else $error("instant trip late");
   fixed_time_a: assert property ($rose(o_trip) && fx |-> o_op_ticks >= i_fixed_delay)
      else $error("fixed trip early");
   rel_hold_a: assert property ($fell(o_start) && !o_blocked && dly |-> $past(o_releasing))
      else $error("start dropped without release");
   blk_release_a: assert property ($rose(o_blocked) && $past(o_start) && dly |-> !o_start && o_releasing)
      else $error("block not handled as drop");
   op_step_a: assert property (o_op_ticks != 19'h00000 && $changed(o_op_ticks)
      |-> o_op_ticks == $past(o_op_ticks) + 19'h00001)
      else $error("operating time jumped");
   rst_clear_a: assert property (disable iff (1'b0) i_sys_rst |=> !o_start && !o_trip && !o_blocked)
      else $error("outputs set after reset");
   cover property ($rose(o_trip));
   cover property ($rose(o_blocked));
   cover property ($fell(o_releasing));
endmodule
bind voltage_stage_trip_release_timer vstage_assertions u_vstage_assertions (.i_clk, .i_sys_rst,
   .i_delay_type, .i_fixed_delay, .i_release_delay, .i_delayed_release, .o_start, .o_trip,
   .o_blocked, .o_releasing, .o_op_ticks);
`default_nettype wire

/* sim/pickup_source.sv */
// pick-up comparator side: voltage ratio and blocking levels
`timescale 1ns/1ps
`default_nettype none
module pickup_source
(
   input wire logic i_clk,
   output logic [15:0] o_ratio,
   output logic o_block
);
   initial
   begin
      o_ratio = 16'h0800;
      o_block = 1'b0;
   end
   // levels move only off the sampling edge
   task set(input logic [15:0] r, input logic b);
      @(negedge i_clk);
      o_ratio = r;
      o_block = b;
   endtask
endmodule
`default_nettype wire

/* sim/voltage_stage_trip_release_timer_bench.sv */
// scenario bench for the stage trip and release timer
`timescale 1ns/1ps
`default_nettype none
module voltage_stage_trip_release_timer_bench;
   logic clk, rst, under, blk, start, trip, blkd, rel;
   logic [15:0] ratio;
   logic [1:0] dtype, drel, raft, cont;
   logic [18:0] fdel, op;
   logic [14:0] rdel;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   int n;
   pickup_source u_pickup_source (.i_clk(clk), .o_ratio(ratio), .o_block(blk));
   // short tick keeps the run small; op figures below count ticks of 8 cycles, waits and n count cycles
   voltage_stage_trip_release_timer #(.TICK_CYCLES(8)) u_voltage_stage_trip_release_timer (
      .i_clk(clk), .i_sys_rst(rst), .i_under(under), .i_ratio(ratio), .i_block(blk),
      .i_delay_type(dtype), .i_fixed_delay(fdel), .i_dial_k(vstage_pkg::DIAL_K_DEF),
      .i_inverse_time_mode_exp(vstage_pkg::EXP_A_DEF), .i_release_delay(rdel), .i_delayed_release(drel),
      .i_reset_after_release(raft),
      .i_continue_release(cont), .o_start(start), .o_trip(trip),
      .o_blocked(blkd), .o_releasing(rel), .o_op_ticks(op));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         summarize();
      end
   end
   task summarize;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [18:0] e, input logic [18:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task cfg(input logic [1:0] t, input logic [18:0] f, input logic [14:0] r, input logic [1:0] d);
      @(negedge clk);
      dtype = t;
      fdel = f;
      rdel = r;
      drel = d;
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return start;
         1: return trip;
         default: return rel;
      endcase
   endfunction
   // bounded wait, n holds the cycles spent
   task wfor(input int w, input logic v);
      n = 0;
      while (pick(w) !== v && n < 600)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   task t_fixed;
      logic [18:0] held;
      cfg(2'h1, 19'h00003, 15'h0004, 2'h2);
      u_pickup_source.set(16'h1100, 1'b0);
      wfor(1, 1'b1);
      chk("op at trip", 19'h00003, op);
      u_pickup_source.set(16'h0fa0, 1'b0);
      repeat (16) @(negedge clk);
      chk("start in band", 19'h00001, start);
      u_pickup_source.set(16'h0f00, 1'b0);
      // the band kept the run going, so freeze is judged against the last run value
      held = op;
      wfor(2, 1'b1);
      chk("start held", 19'h00001, start);
      chk("trip in release", 19'h00000, trip);
      chk("op frozen", held, op);
      wfor(0, 1'b0);
      chk("release cycles", 19'd24, n[18:0]);
      chk("op cleared", 19'h00000, op);
   endtask
   task t_instant;
      cfg(2'h1, 19'h00000, 15'h0004, 2'h1);
      u_pickup_source.set(16'h1100, 1'b0);
      wfor(0, 1'b1);
      chk("trip with start", 19'h00001, trip);
      u_pickup_source.set(16'h0f00, 1'b0);
      wfor(0, 1'b0);
      chk("direct drop", 19'h00001, n <= 8);
      repeat (48) @(negedge clk);
   endtask
   task t_block;
      cfg(2'h1, 19'h0000a, 15'h0004, 2'h2);
      u_pickup_source.set(16'h1100, 1'b1);
      repeat (24) @(negedge clk);
      chk("blocked", 19'h00001, blkd);
      chk("no timer", 19'h00000, op);
      u_pickup_source.set(16'h0f00, 1'b0);
      repeat (48) @(negedge clk);
      u_pickup_source.set(16'h1100, 1'b0);
      wfor(0, 1'b1);
      u_pickup_source.set(16'h1100, 1'b1);
      wfor(2, 1'b1);
      chk("start at block", 19'h00000, start);
      u_pickup_source.set(16'h0f00, 1'b0);
      repeat (48) @(negedge clk);
   endtask
   task t_continue;
      logic [18:0] held;
      cfg(2'h1, 19'h00006, 15'h0004, 2'h2);
      cont = vstage_pkg::SEL_YES;
      u_pickup_source.set(16'h1100, 1'b0);
      wfor(0, 1'b1);
      repeat (8) @(negedge clk);
      u_pickup_source.set(16'h0f00, 1'b0);
      wfor(2, 1'b1);
      held = op;
      repeat (8) @(negedge clk);
      chk("op counts in release", held + 19'h00001, op);
      chk("no trip in release", 19'h00000, trip);
      wfor(0, 1'b0);
      chk("op cleared after", 19'h00000, op);
      cont = vstage_pkg::SEL_NO;
      raft = vstage_pkg::SEL_NO;
      u_pickup_source.set(16'h1100, 1'b0);
      wfor(0, 1'b1);
      repeat (8) @(negedge clk);
      u_pickup_source.set(16'h0f00, 1'b0);
      wfor(2, 1'b1);
      chk("op cleared at drop", 19'h00000, op);
      repeat (48) @(negedge clk);
      raft = vstage_pkg::SEL_YES;
   endtask
   task t_inverse;
      cfg(2'h2, 19'h00000, 15'h0004, 2'h2);
      u_pickup_source.set(16'h2000, 1'b0);
      wfor(1, 1'b1);
      chk("inverse over", 19'h00001, op >= 19'd9 && op <= 19'd11);
      // 1.0 sits inside the hysteresis band, so drop well below it to end the run
      u_pickup_source.set(16'h0f00, 1'b0);
      repeat (64) @(negedge clk);
      u_pickup_source.set(16'h0800, 1'b0);
      under = 1'b1;
      wfor(1, 1'b1);
      chk("inverse under", 19'h00001, op >= 19'd19 && op <= 19'd21);
   endtask
   initial
   begin
      under = 1'b0;
      dtype = 2'h1;
      fdel = 19'h00003;
      rdel = 15'h0004;
      drel = 2'h2;
      raft = vstage_pkg::RESET_AFTER_DEF;
      cont = vstage_pkg::CONTINUE_DEF;
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      chk("op after reset", 19'h00000, op);
      t_fixed();
      t_instant();
      t_block();
      t_continue();
      t_inverse();
      summarize();
   end
endmodule
`default_nettype wire
